/* File: verilog/dmc_consts.svh */
// Purpose: Register indices, field values, reset values and timing counts for direct commands.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef DMC_CONSTS_SVH
`define DMC_CONSTS_SVH

`define DMC_IDX_ITEM_BASE   10'd88
`define DMC_IDX_ITEM_LAST   10'd100
`define DMC_IDX_TRIGGER     10'd102
`define DMC_IDX_DEST        10'd104
`define DMC_IDX_ZERO_ACT    10'd112
`define DMC_IDX_STATUS      10'd113
`define DMC_IDX_TBL_ADDR    10'd114
`define DMC_IDX_TBL_DATA    10'd115

`define DMC_ITEMS           7
`define DMC_ITEM_TYPE       3'd1
`define DMC_ITEM_SPEED      3'd3
`define DMC_SEL_OFFSET      32'h0000_0007

`define DMC_TRIG_OFF        32'h0000_0000
`define DMC_TRIG_ALL        32'h0000_0001
`define DMC_TRIG_SEL_FIRST  32'hFFFF_FFF9
`define DMC_DEST_EXEC       32'h0000_0000
`define DMC_DEST_BUF        32'h0000_0001
`define DMC_ZERO_DECEL      1'b0
`define DMC_ZERO_HOLD       1'b1

`define DMC_TYPE_CONT_POS   32'h0000_0007
`define DMC_TYPE_CONT_SPD   32'h0000_0010
`define DMC_TYPE_CONT_TRQ   32'h0000_0011

`define DMC_ST_READY        0
`define DMC_ST_FULL         1
`define DMC_ST_RUNNING      2
`define DMC_ST_ZERO_HOLD    3

`define DMC_CLK_NS          100
`define DMC_TX_WAIT_NS      100000
`define DMC_SILENT_NS       100000
`define DMC_PROC_NS         100000
`define DMC_START_EXTRA_NS  4000000
`define DMC_REPLY_CYC       ((`DMC_TX_WAIT_NS + `DMC_SILENT_NS + `DMC_PROC_NS + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`define DMC_START_MAX_CYC   ((`DMC_SILENT_NS + `DMC_START_EXTRA_NS) / `DMC_CLK_NS)

`endif

/* File: verilog/dmc_pkg.sv */
// Purpose: Types shared by the direct motion command block.
// Assumes: Constants live in dmc_consts.svh.
// Notes:   None.
package dmc_pkg;
    typedef enum logic [0:0] {DMC_LOAD, DMC_RUN} dmc_state_e;
    typedef logic [31:0] dmc_word_t;
endpackage

/* File: verilog/dmc_entry_mem.sv */
// Purpose: Stored operation entries, eight words per entry, registered read.
// Assumes: Single clock, one write and one read port.
// Notes:   Contents are not reset and survive rst_b.
module dmc_entry_mem #(
    parameter int AW = 11,
    parameter int DW = 32
) (
    input  wire logic          clk,   // system clock
    input  wire logic          we,    // write strobe
    input  wire logic [AW-1:0] waddr, // write address
    input  wire logic [DW-1:0] wdata, // write data
    input  wire logic [AW-1:0] raddr, // read address
    output logic      [DW-1:0] rdata  // read data, one cycle late
);
    logic [DW-1:0] mem [1 << AW];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule

/* File: verilog/dmc_direct_trigger.sv */
// Purpose: Direct motion command trigger, destination and one-entry buffer behind APB.
// Assumes: motor_stopped_in comes from motion logic on clk; registers at index*4.
// Notes:   Every APB access waits REPLY_CYC cycles before pready.
// Contract
// - Trigger 1 takes all data, starts motion, then trigger returns to 0.
// - Negative selector starts motion when the selected item is written.
// - A selector trigger is kept after starting, so rewrites restart motion.
// - Valid query drops ready and starts motion; ready returns at stop.
// - Start within silent interval plus 4 ms of the query end.
// - Reply no earlier than wait time, silent interval and processing time.
// - Destination 0 means replace running command, 1 means buffer.
// - Immediate destination replaces running data and discards any buffered entry.
// - Buffered destination stores data and starts it when current motion completes.
// - The buffer holds exactly one pending entry.
// - Buffer-full output is set while an entry waits in the buffer.
// - When stopped or in continuous motion, new data applies at once.
// - Zero speed uses zero-speed action: 0 decelerates, 1 holds zero speed.
// - Under zero-speed hold, status stays in the operating state.
// - Trigger loads from an initial value between -7 and 0.
// - Destination loads from an initial value of 0 or 1.
// - Initial direct data come from the stored entry at a 0 to 255 index.
// - Trigger is a 32-bit value written over the register interface.
// - Destination is a 32-bit value written over the register interface; the code stores only bit 0 of the written value.
//
// Decided for this implementation: register access over APB and the register addresses.
`include "dmc_consts.svh"
module dmc_direct_trigger #(
    parameter logic [31:0] TRIG_INIT = `DMC_TRIG_OFF,
    parameter logic [31:0] DEST_INIT = `DMC_DEST_EXEC,
    parameter logic [7:0]  REF_INDEX = 8'h00,
    parameter int          REPLY_CYC = `DMC_REPLY_CYC
) (
    input  wire logic        clk,                    // system clock, 10 MHz
    input  wire logic        rst_b,                  // synchronous reset, active low
    input  wire logic        psel,                   // APB select
    input  wire logic        penable,                // APB enable
    input  wire logic        pwrite,                 // APB direction
    input  wire logic [11:0] paddr,                  // APB byte address
    input  wire logic [31:0] pwdata,                 // APB write data
    output logic      [31:0] prdata,                 // APB read data
    output logic             pready,                 // APB ready
    output logic             pslverr,                // APB error on unmapped address
    input  wire logic        motor_stopped_in,       // motion finished pulse
    output logic             cmd_start_out,          // start motion pulse
    output logic             cmd_stop_out,           // decelerate to stop pulse
    output logic      [31:0] cmd_data_num_out,       // running operation data number
    output logic      [31:0] cmd_type_out,           // running operation type
    output logic      [31:0] cmd_pos_out,            // running position
    output logic      [31:0] cmd_speed_out,          // running speed
    output logic      [31:0] cmd_rate_out,           // running speed rate
    output logic      [31:0] cmd_decel_out,          // running stop deceleration
    output logic      [31:0] cmd_current_out,        // running current
    output logic             direct_cmd_ready_out,   // ready for a direct query
    output logic             direct_buffer_full_out, // an entry waits in the buffer
    output logic             in_operation_out,       // operating status
    output logic             zero_speed_hold_out     // zero speed command in force
);
    localparam int START_MAX_CYC = `DMC_START_MAX_CYC;

    if (REPLY_CYC < 2 || REPLY_CYC > 65535 || START_MAX_CYC < 1) begin : g_bad_timing
        $error("dmc_direct_trigger: reply or start count out of range");
    end
    if (!(TRIG_INIT == `DMC_TRIG_OFF || TRIG_INIT >= `DMC_TRIG_SEL_FIRST)
        || DEST_INIT > `DMC_DEST_BUF) begin : g_bad_init
        $error("dmc_direct_trigger: initial trigger or destination out of range");
    end

    function automatic logic item_hit(input logic [9:0] idx);
        return idx >= `DMC_IDX_ITEM_BASE && idx <= `DMC_IDX_ITEM_LAST && !idx[0];
    endfunction

    function automatic logic [2:0] item_of(input logic [9:0] idx);
        logic [9:0] d;
        d = idx - `DMC_IDX_ITEM_BASE;
        return d[3:1];
    endfunction

    function automatic logic is_cont(input logic [31:0] t);
        return t == `DMC_TYPE_CONT_POS || t == `DMC_TYPE_CONT_SPD || t == `DMC_TYPE_CONT_TRQ;
    endfunction

    dmc_pkg::dmc_state_e state_reg;
    logic [2:0]          load_cnt_reg;
    logic [15:0]         wait_cnt_reg;
    logic [31:0]         trig_reg;
    logic [31:0]         dest_reg;
    logic                zero_act_reg;
    logic [10:0]         tbl_addr_reg;
    logic                running_reg;
    logic                full_reg;
    logic [31:0]         mem_rdata;
    dmc_pkg::dmc_word_t  data_reg [`DMC_ITEMS];
    dmc_pkg::dmc_word_t  data_next [`DMC_ITEMS];
    dmc_pkg::dmc_word_t  exec_reg [`DMC_ITEMS];
    dmc_pkg::dmc_word_t  buf_reg [`DMC_ITEMS];
    dmc_pkg::dmc_word_t  launch_data [`DMC_ITEMS];

    logic [9:0] widx;
    logic       mapped;
    logic       wr_done;
    logic       all_fire;
    logic       sel_fire;
    logic       fire;
    logic       apply_now;
    logic       to_buf;
    logic       launch_buf;
    logic       launch;
    logic       zero_stop;

    assign widx    = paddr[11:2];
    assign mapped  = item_hit(widx) || widx == `DMC_IDX_TRIGGER || widx == `DMC_IDX_DEST
                     || widx == `DMC_IDX_ZERO_ACT || widx == `DMC_IDX_STATUS
                     || widx == `DMC_IDX_TBL_ADDR || widx == `DMC_IDX_TBL_DATA;
    assign pready  = psel && penable && state_reg == dmc_pkg::DMC_RUN
                     && wait_cnt_reg == 16'(REPLY_CYC - 1);
    assign pslverr = pready && !mapped;
    assign wr_done = pready && pwrite && mapped;

    // Counts access-phase cycles so the reply leaves no earlier than the set time.
    always_ff @(posedge clk) begin
        if (!rst_b || !(psel && penable) || pready) begin
            wait_cnt_reg <= 16'h0000;
        end else if (state_reg == dmc_pkg::DMC_RUN) begin
            wait_cnt_reg <= wait_cnt_reg + 16'h0001;
        end
    end

    assign all_fire = wr_done && widx == `DMC_IDX_TRIGGER && pwdata == `DMC_TRIG_ALL;
    assign sel_fire = wr_done && item_hit(widx)
                      && trig_reg == {29'h0000_0000, item_of(widx)} - `DMC_SEL_OFFSET;
    assign fire     = all_fire || sel_fire;
    assign apply_now  = fire && !(dest_reg == `DMC_DEST_BUF && running_reg
                                  && !is_cont(exec_reg[`DMC_ITEM_TYPE]));
    assign to_buf     = fire && !apply_now;
    assign launch_buf = motor_stopped_in && running_reg && full_reg && !apply_now;
    assign launch     = apply_now || launch_buf;
    assign zero_stop  = launch && launch_data[`DMC_ITEM_SPEED] == 32'h0000_0000
                        && zero_act_reg == `DMC_ZERO_DECEL;

    always_comb begin
        for (int k = 0; k < `DMC_ITEMS; k++) begin
            data_next[k]   = (wr_done && item_hit(widx) && item_of(widx) == 3'(k))
                             ? pwdata : data_reg[k];
            launch_data[k] = apply_now ? data_next[k] : buf_reg[k];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg    <= dmc_pkg::DMC_LOAD;
            load_cnt_reg <= 3'h0;
        end else if (state_reg == dmc_pkg::DMC_LOAD) begin
            load_cnt_reg <= load_cnt_reg + 3'h1;
            if (load_cnt_reg == 3'h7) begin
                state_reg <= dmc_pkg::DMC_RUN;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int k = 0; k < `DMC_ITEMS; k++) begin
                data_reg[k] <= 32'h0000_0000;
            end
        end else if (state_reg == dmc_pkg::DMC_LOAD) begin
            if (load_cnt_reg != 3'h0) begin
                data_reg[load_cnt_reg - 3'h1] <= mem_rdata;
            end
        end else begin
            data_reg <= data_next;
        end
    end

    dmc_entry_mem #(
        .AW (11),
        .DW (32)
    ) u_mem (
        .clk   (clk),
        .we    (wr_done && widx == `DMC_IDX_TBL_DATA),
        .waddr (tbl_addr_reg),
        .wdata (pwdata),
        .raddr ({REF_INDEX, load_cnt_reg}),
        .rdata (mem_rdata)
    );

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            trig_reg     <= TRIG_INIT;
            dest_reg     <= DEST_INIT;
            zero_act_reg <= `DMC_ZERO_DECEL;
            tbl_addr_reg <= 11'h000;
        end else if (wr_done) begin
            unique case (widx)
                `DMC_IDX_TRIGGER:  trig_reg <= all_fire ? `DMC_TRIG_OFF : pwdata;
                `DMC_IDX_DEST:     dest_reg <= {31'h0000_0000, pwdata[0]};
                `DMC_IDX_ZERO_ACT: zero_act_reg <= pwdata[0];
                `DMC_IDX_TBL_ADDR: tbl_addr_reg <= pwdata[10:0];
                `DMC_IDX_TBL_DATA: tbl_addr_reg <= tbl_addr_reg + 11'h001;
                default:           trig_reg <= trig_reg;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (item_hit(widx)) begin
            prdata <= data_reg[item_of(widx)];
        end else begin
            unique case (widx)
                `DMC_IDX_TRIGGER:  prdata <= trig_reg;
                `DMC_IDX_DEST:     prdata <= dest_reg;
                `DMC_IDX_ZERO_ACT: prdata <= {31'h0000_0000, zero_act_reg};
                `DMC_IDX_STATUS:   prdata <= {28'h000_0000, zero_speed_hold_out,
                                              running_reg, full_reg, direct_cmd_ready_out};
                `DMC_IDX_TBL_ADDR: prdata <= {21'h00_0000, tbl_addr_reg};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            full_reg <= 1'b0;
            for (int k = 0; k < `DMC_ITEMS; k++) begin
                exec_reg[k] <= 32'h0000_0000;
                buf_reg[k]  <= 32'h0000_0000;
            end
        end else begin
            if (launch) begin
                exec_reg <= launch_data;
            end
            if (to_buf) begin
                buf_reg  <= data_next;
                full_reg <= 1'b1;
            end else if (launch_buf || (apply_now && dest_reg == `DMC_DEST_EXEC)) begin
                full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            running_reg         <= 1'b0;
            cmd_start_out       <= 1'b0;
            cmd_stop_out        <= 1'b0;
            zero_speed_hold_out <= 1'b0;
        end else begin
            cmd_start_out <= launch && !zero_stop;
            cmd_stop_out  <= zero_stop;
            if (launch && !zero_stop) begin
                running_reg         <= 1'b1;
                zero_speed_hold_out <= launch_data[`DMC_ITEM_SPEED] == 32'h0000_0000;
            end else if (motor_stopped_in || (zero_stop && launch_buf)) begin
                running_reg         <= 1'b0;
                zero_speed_hold_out <= 1'b0;
            end
        end
    end

    assign cmd_data_num_out       = exec_reg[0];
    assign cmd_type_out           = exec_reg[1];
    assign cmd_pos_out            = exec_reg[2];
    assign cmd_speed_out          = exec_reg[3];
    assign cmd_rate_out           = exec_reg[4];
    assign cmd_decel_out          = exec_reg[5];
    assign cmd_current_out        = exec_reg[6];
    assign direct_cmd_ready_out   = state_reg == dmc_pkg::DMC_RUN && !running_reg;
    assign direct_buffer_full_out = full_reg;
    assign in_operation_out       = running_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_all_clears: assert property (all_fire |=> trig_reg == `DMC_TRIG_OFF &&
                                     (cmd_start_out || cmd_stop_out || full_reg))
        else $error("trigger 1 did not clear or start");
    chk_sel_starts: assert property (sel_fire && apply_now |=> cmd_start_out || cmd_stop_out)
        else $error("selected item write did not start motion");
    chk_sel_keeps: assert property (sel_fire |=> $stable(trig_reg))
        else $error("selector trigger was not kept");
    chk_ready_drop: assert property (apply_now && !zero_stop |=> !direct_cmd_ready_out)
        else $error("ready stayed high after start");
    chk_ready_back: assert property (motor_stopped_in && running_reg && !full_reg && !fire
                                     |=> direct_cmd_ready_out)
        else $error("ready not restored at stop");
    chk_start_bound: assert property (launch |-> ##1 (cmd_start_out || cmd_stop_out))
        else $error("start late after query");
    chk_reply_wait: assert property (pready |-> $past(psel && penable && !pready))
        else $error("reply too early");
    chk_exec_clear: assert property (apply_now && dest_reg == `DMC_DEST_EXEC |=> !full_reg)
        else $error("buffer not discarded on replace");
    chk_buf_store: assert property (to_buf && !launch_buf |=> full_reg &&
                                    direct_buffer_full_out && !cmd_start_out)
        else $error("buffered entry not flagged");
    chk_buf_launch: assert property (launch_buf && !to_buf |=>
                                     !full_reg && (cmd_start_out || cmd_stop_out))
        else $error("buffered entry not started at completion");
    chk_cont_apply: assert property (fire && running_reg
                                     && is_cont(exec_reg[`DMC_ITEM_TYPE])
                                     |=> cmd_start_out || cmd_stop_out)
        else $error("continuous motion buffered new data");
    chk_zero_decel: assert property (zero_stop |=> cmd_stop_out && !cmd_start_out)
        else $error("zero speed did not decelerate");
    chk_init_first: assert property (state_reg == dmc_pkg::DMC_LOAD
                                     |-> !pready && !direct_cmd_ready_out)
        else $error("query accepted before initial load");

    cov_all_start: cover property (all_fire ##1 cmd_start_out);
    cov_buf_chain: cover property (to_buf ##[1:1000] launch_buf);
    cov_sel_twice: cover property (sel_fire ##[1:1000] sel_fire);
    cov_zero_hold: cover property (launch && zero_act_reg && !zero_stop
                                   && launch_data[`DMC_ITEM_SPEED] == 32'h0000_0000);
endmodule

/* File: verification/dmc_motor_model.sv */
// Purpose: Motion logic model that reports a motor stop after each run.
// Assumes: Start and stop pulses are one clk cycle wide.
// Notes:   Continuous types run until a stop pulse, then decelerate for 4 cycles.
`include "dmc_consts.svh"
module dmc_motor_model #(
    parameter int RUN_CYC = 60
) (
    input  wire logic        clk,      // system clock
    input  wire logic        rst_b,    // synchronous reset, active low
    input  wire logic        start,    // start motion pulse
    input  wire logic        stop,     // decelerate to stop pulse
    input  wire logic [31:0] cmd_type, // running operation type
    output logic             stopped   // motor stopped pulse
);
    logic [15:0] cnt_reg;
    logic        cont;

    assign cont = (cmd_type == `DMC_TYPE_CONT_POS) || (cmd_type == `DMC_TYPE_CONT_SPD)
                  || (cmd_type == `DMC_TYPE_CONT_TRQ);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_reg <= 16'h0000;
            stopped <= 1'b0;
        end else begin
            stopped <= cnt_reg == 16'h0001 && !start && !stop;
            if (start) begin
                cnt_reg <= cont ? 16'h0000 : 16'(RUN_CYC);
            end else if (stop) begin
                cnt_reg <= 16'h0004;
            end else if (cnt_reg != 16'h0000) begin
                cnt_reg <= cnt_reg - 16'h0001;
            end
        end
    end
endmodule

/* File: verification/dmc_direct_trigger_bench.sv */
// Purpose: Self-checking bench for the direct motion trigger block.
// Assumes: APB master tasks; motion logic stands in as dmc_motor_model.
// Notes:   Start and stop pulses are counted on the falling edge.
`include "dmc_consts.svh"
module dmc_direct_trigger_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int          RCYC  = 3;
    localparam logic [7:0]  REF   = 8'h01;
    localparam logic [31:0] TINIT = 32'hFFFF_FFFC;
    localparam logic [9:0]  TRG   = `DMC_IDX_TRIGGER;
    localparam logic [9:0]  DST   = `DMC_IDX_DEST;
    localparam logic [9:0]  ZAC   = `DMC_IDX_ZERO_ACT;
    localparam logic [9:0]  STS   = `DMC_IDX_STATUS;
    localparam logic [9:0]  TYP   = `DMC_IDX_ITEM_BASE + 10'd2;
    localparam logic [9:0]  POSI  = `DMC_IDX_ITEM_BASE + 10'd4;
    localparam logic [9:0]  SPD   = `DMC_IDX_ITEM_BASE + 10'd6;
    localparam logic [31:0] INIT_W [7] = '{32'h0000_0003, 32'h0000_0001, 32'h0000_0040,
        32'h0000_03E8, 32'h000F_4240, 32'h000F_4240, 32'h0000_03E8};
    typedef struct packed {
        logic [9:0]  idx;
        logic [31:0] wd;
        logic [31:0] exp;
        logic        er;
    } dmc_row_s;
    localparam dmc_row_s ROWS [9] = '{'{TRG, 32'hFFFF_FFFD, 32'hFFFF_FFFD, 1'b0},
        '{TRG, 32'h0000_0000, 32'h0000_0000, 1'b0}, '{DST, 32'h0000_0001, 32'h0000_0001, 1'b0},
        '{DST, 32'h0000_0000, 32'h0000_0000, 1'b0}, '{ZAC, 32'h0000_0001, 32'h0000_0001, 1'b0},
        '{ZAC, 32'h0000_0000, 32'h0000_0000, 1'b0}, '{POSI, 32'h0000_1234, 32'h0000_1234, 1'b0},
        '{STS, 32'h0000_000F, 32'h0000_0001, 1'b0}, '{10'd200, 32'h0000_5555, 32'h0000_0000, 1'b1}};
    logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, stopped, start, stop, ready, full, in_op, zhold, err;
    logic [31:0] cmd [7];
    int          failures = 0, n_compared = 0, n_start = 0, n_stop = 0, s0 = 0;

    always #50 clk = ~clk;
    always @(negedge clk) begin
        if (start === 1'b1) n_start++;
        if (stop === 1'b1) n_stop++;
    end

    dmc_direct_trigger #(.TRIG_INIT(TINIT), .DEST_INIT(32'h0000_0001), .REF_INDEX(REF),
        .REPLY_CYC(RCYC)) dmc_direct_trigger_inst (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .motor_stopped_in(stopped), .cmd_start_out(start), .cmd_stop_out(stop),
        .cmd_data_num_out(cmd[0]), .cmd_type_out(cmd[1]), .cmd_pos_out(cmd[2]),
        .cmd_speed_out(cmd[3]), .cmd_rate_out(cmd[4]), .cmd_decel_out(cmd[5]),
        .cmd_current_out(cmd[6]), .direct_cmd_ready_out(ready), .direct_buffer_full_out(full),
        .in_operation_out(in_op), .zero_speed_hold_out(zhold));
    dmc_motor_model #(.RUN_CYC(60)) dmc_motor_model_inst (.clk(clk), .rst_b(rst_b),
        .start(start), .stop(stop), .cmd_type(cmd[1]), .stopped(stopped));

    task finish_test;
        if (failures == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (pready !== 1'b1 && i < 500);
        if (pready !== 1'b1) begin
            failures++;
            $display("Error at %0t ns: no pready", $time);
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        chk({31'h0, i >= RCYC}, 1'b1);
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask

    task wr(input logic [9:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask

    task rdc(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task starts(input int e);
        chk(32'(n_start - s0), 32'(e));
        s0 = n_start;
    endtask

    task wait_on(input int sel, input logic val);
        int i;
        for (i = 0; i < 400; i++) begin
            @(negedge clk);
            if (((sel == 0) ? ready : full) === val) break;
        end
        if (i == 400) begin
            failures++;
            $display("Error at %0t ns: wait timed out", $time);
            finish_test();
        end
        @(posedge clk);
        @(negedge clk);
    endtask

    initial begin
        int k;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk(ready, 1'b0);
        wait_on(0, 1'b1);
        rdc(TRG, TINIT);
        rdc(DST, 32'h0000_0001);
        wr(`DMC_IDX_TBL_ADDR, 32'({REF, 3'b000}));
        for (k = 0; k < 7; k++) wr(`DMC_IDX_TBL_DATA, INIT_W[k]);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk(ready, 1'b0);
        wait_on(0, 1'b1);
        for (k = 0; k < 7; k++) rdc(10'(`DMC_IDX_ITEM_BASE + 2 * k), INIT_W[k]);
        for (int r = 0; r < 9; r++) begin
            wr(ROWS[r].idx, ROWS[r].wd);
            chk(err, ROWS[r].er);
            rdc(ROWS[r].idx, ROWS[r].exp);
            chk(err, ROWS[r].er);
        end
        wait_on(0, 1'b1);
        wr(TYP, 32'h0000_0001);
        wr(POSI, 32'h0000_0100);
        s0 = n_start;
        wr(TRG, `DMC_TRIG_ALL);
        starts(1);
        chk(cmd[2], 32'h0000_0100);
        chk({ready, in_op}, 2'b01);
        rdc(TRG, 32'h0000_0000);
        wait_on(0, 1'b1);
        for (k = 0; k < 7; k++) begin
            wr(TRG, `DMC_TRIG_SEL_FIRST + k);
            wr(10'(`DMC_IDX_ITEM_BASE + 2 * k), 32'h0000_0100 + k);
            starts(1);
            chk(cmd[k], 32'h0000_0100 + k);
            wr(10'(`DMC_IDX_ITEM_BASE + 2 * k), 32'h0000_0100 + k);
            starts(1);
            rdc(TRG, `DMC_TRIG_SEL_FIRST + k);
        end
        wr(TRG, `DMC_TRIG_OFF);
        wr(TYP, 32'h0000_0001);
        wait_on(0, 1'b1);
        wr(DST, `DMC_DEST_BUF);
        wr(POSI, 32'h0000_0150);
        wr(TRG, `DMC_TRIG_ALL);
        starts(1);
        chk(full, 1'b0);
        wr(POSI, 32'h0000_0200);
        wr(TRG, `DMC_TRIG_ALL);
        chk(full, 1'b1);
        wr(POSI, 32'h0000_0300);
        wr(TRG, `DMC_TRIG_ALL);
        starts(0);
        chk(cmd[2], 32'h0000_0150);
        wait_on(1, 1'b0);
        starts(1);
        chk(cmd[2], 32'h0000_0300);
        wr(POSI, 32'h0000_0400);
        wr(TRG, `DMC_TRIG_ALL);
        chk(full, 1'b1);
        wr(DST, `DMC_DEST_EXEC);
        wr(POSI, 32'h0000_0500);
        wr(TRG, `DMC_TRIG_ALL);
        starts(1);
        chk(full, 1'b0);
        chk(cmd[2], 32'h0000_0500);
        wait_on(0, 1'b1);
        wr(DST, `DMC_DEST_BUF);
        wr(TYP, `DMC_TYPE_CONT_SPD);
        wr(TRG, `DMC_TRIG_ALL);
        wr(TRG, `DMC_TRIG_ALL);
        starts(2);
        chk(full, 1'b0);
        wr(SPD, 32'h0000_0000);
        wr(TRG, `DMC_TRIG_ALL);
        chk(32'(n_stop), 32'h0000_0001);
        wait_on(0, 1'b1);
        s0 = n_start;
        wr(ZAC, 32'h0000_0001);
        wr(TRG, `DMC_TRIG_ALL);
        starts(1);
        chk({zhold, in_op}, 2'b11);
        finish_test();
    end
endmodule
